// ===== common/twf_pkg.sv
package twf_pkg;
  // Word framing
  localparam int TWF_WORD_BITS = 8;
  localparam logic [3:0] TWF_BIT_ZERO = 4'h0;
  localparam logic [3:0] TWF_BIT_ONE = 4'h1;
  localparam logic [3:0] TWF_BIT_LAST = 4'h7;
  localparam logic [3:0] TWF_BIT_FULL = 4'h8;
  localparam logic [7:0] TWF_BYTE_ZERO = 8'h00;
  // Receive buffer
  localparam int TWF_FIFO_DEPTH = 8;
  // Internal write cycle time
  localparam int unsigned TWF_CLK_KHZ = 250_000;
  localparam int unsigned TWF_INTERNAL_WRITE_CYCLE_TIME_MS = 5;
  localparam int unsigned TWF_WRITE_CYCLES = TWF_INTERNAL_WRITE_CYCLE_TIME_MS * TWF_CLK_KHZ;
  localparam int TWF_WCNT_W = 21;
  localparam logic [TWF_WCNT_W-1:0] TWF_WCNT_ZERO = 21'h0;
  localparam logic [TWF_WCNT_W-1:0] TWF_WCNT_ONE = 21'h1;
  typedef enum logic [2:0] {
    TWF_IDLE = 3'h0,
    TWF_RX = 3'h1,
    TWF_ACK_RX = 3'h2,
    TWF_TX = 3'h3,
    TWF_ACK_TX = 3'h4,
    TWF_WAIT_STOP = 3'h5
  } twf_state_e;
endpackage

// ===== common/twf_fifo_if.sv
`timescale 1ns/1ps
interface twf_fifo_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ===== design/twf_fifo.sv
`timescale 1ns/1ps
module twf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  twf_fifo_if.snk fill,
  twf_fifo_if.src drain
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] PTR_ZERO = '0;
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_ZERO = '0;
  localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign fill.ready = (count != CNT_FULL);
  assign drain.valid = (count != CNT_ZERO);
  assign drain.data = mem[rd_ptr];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= PTR_ZERO;
      rd_ptr <= PTR_ZERO;
      count <= CNT_ZERO;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? PTR_ZERO : wr_ptr + PTR_ONE;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? PTR_ZERO : rd_ptr + PTR_ONE;
      end
      if (push && !pop) begin
        count <= count + CNT_ONE;
      end else if (pop && !push) begin
        count <= count - CNT_ONE;
      end
    end
  end
endmodule

// ===== design/twf_top.sv
`timescale 1ns/1ps
// Contract
// - Data line changes only while clock low; changes while high are start or stop.
// - Start is data falling with clock high; device begins a new command; here, while an internal write is busy, it waits for stop instead.
// - Stop is data rising with clock high; device ends the current sequence.
// - Stop after a read sequence puts the device in standby until next start.
// - Words are eight bits, one bit per serial clock, in both directions.
// - Device pulls data low during the ninth clock after each received word; here it does not when the receive buffer is full or an internal write is busy.
// - Stop after a write sequence runs a self-timed internal write within 5 ms.
// - Incoming bits sampled on clock rise; outgoing bits change after clock fall.
// - Data line is only pulled low or released, never driven high.
module twf_top
  import twf_pkg::*;
#(
  parameter int unsigned P_WRITE_CYCLES = TWF_WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_dir_read,
  input wire logic i_tx_valid,
  input wire logic [TWF_WORD_BITS-1:0] i_tx_data,
  output logic o_tx_take,
  output logic o_rx_valid,
  output logic [TWF_WORD_BITS-1:0] o_rx_data,
  input wire logic i_rx_ready,
  output logic o_standby,
  output logic o_write_busy
);
  localparam logic [TWF_WCNT_W-1:0] WCNT_LOAD = TWF_WCNT_W'(P_WRITE_CYCLES - 1);

  logic scl_m;
  logic scl_q;
  logic scl_p;
  logic sda_m;
  logic sda_q;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic word_fall;
  twf_state_e state;
  logic [3:0] bit_cnt;
  logic [TWF_WORD_BITS-1:0] rx_sh;
  logic [TWF_WORD_BITS-1:0] tx_sh;
  logic first_word;
  logic wrote;
  logic read_seq;
  logic host_ack;
  logic [TWF_WCNT_W-1:0] wr_cnt;

  twf_fifo_if #(.W(TWF_WORD_BITS)) wr_if ();
  twf_fifo_if #(.W(TWF_WORD_BITS)) rd_if ();

  twf_fifo #(
    .W(TWF_WORD_BITS),
    .DEPTH(TWF_FIFO_DEPTH)
  ) twf_fifo_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .fill(wr_if.snk),
    .drain(rd_if.src)
  );

  // Two-stage synchronisers plus one history stage for edge finding
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_m <= 1'b1;
      scl_q <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_q <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= i_scl;
      scl_q <= scl_m;
      scl_p <= scl_q;
      sda_m <= i_sda_i;
      sda_q <= sda_m;
      sda_p <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_p;
  assign scl_fall = !scl_q && scl_p;
  assign start_det = scl_q && scl_p && sda_p && !sda_q;
  assign stop_det = scl_q && scl_p && !sda_p && sda_q;
  assign word_fall = scl_fall && (state == TWF_RX) && (bit_cnt == TWF_BIT_FULL);

  // Received word enters the buffer at the fall ending its eighth bit
  assign wr_if.valid = word_fall;
  assign wr_if.data = rx_sh;

  // Open-drain: the driven level is always low
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sda_o <= 1'b0;
    end else begin
      o_sda_o <= 1'b0;
    end
  end

  // Bit and word framing
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= TWF_IDLE;
      bit_cnt <= TWF_BIT_ZERO;
      rx_sh <= TWF_BYTE_ZERO;
      tx_sh <= TWF_BYTE_ZERO;
      o_sda_oe <= 1'b0;
      first_word <= 1'b0;
      wrote <= 1'b0;
      read_seq <= 1'b0;
      host_ack <= 1'b0;
      o_tx_take <= 1'b0;
    end else begin
      o_tx_take <= 1'b0;
      if (start_det) begin
        bit_cnt <= TWF_BIT_ZERO;
        o_sda_oe <= 1'b0;
        first_word <= 1'b1;
        wrote <= 1'b0;
        read_seq <= 1'b0;
        host_ack <= 1'b0;
        // Busy writing: stay silent so polling sees no acknowledge
        state <= o_write_busy ? TWF_WAIT_STOP : TWF_RX;
      end else if (stop_det) begin
        bit_cnt <= TWF_BIT_ZERO;
        o_sda_oe <= 1'b0;
        state <= TWF_IDLE;
      end else begin
        unique case (state)
          TWF_IDLE, TWF_WAIT_STOP: begin
            o_sda_oe <= 1'b0;
          end
          TWF_RX: begin
            if (scl_rise && bit_cnt != TWF_BIT_FULL) begin
              rx_sh <= {rx_sh[TWF_WORD_BITS-2:0], sda_q};
              bit_cnt <= bit_cnt + TWF_BIT_ONE;
            end
            if (word_fall) begin
              bit_cnt <= TWF_BIT_ZERO;
              if (wr_if.ready) begin
                o_sda_oe <= 1'b1;
                state <= TWF_ACK_RX;
              end else begin
                state <= TWF_WAIT_STOP;
              end
            end
          end
          TWF_ACK_RX: begin
            if (scl_fall) begin
              first_word <= 1'b0;
              if (first_word && i_dir_read) begin
                read_seq <= 1'b1;
                if (i_tx_valid) begin
                  tx_sh <= i_tx_data;
                  o_sda_oe <= !i_tx_data[TWF_WORD_BITS-1];
                  o_tx_take <= 1'b1;
                  state <= TWF_TX;
                end else begin
                  o_sda_oe <= 1'b0;
                  state <= TWF_WAIT_STOP;
                end
              end else begin
                o_sda_oe <= 1'b0;
                if (!first_word) begin
                  wrote <= 1'b1;
                end
                state <= TWF_RX;
              end
            end
          end
          TWF_TX: begin
            if (scl_fall) begin
              if (bit_cnt == TWF_BIT_LAST) begin
                bit_cnt <= TWF_BIT_ZERO;
                o_sda_oe <= 1'b0;
                host_ack <= 1'b0;
                state <= TWF_ACK_TX;
              end else begin
                bit_cnt <= bit_cnt + TWF_BIT_ONE;
                tx_sh <= {tx_sh[TWF_WORD_BITS-2:0], 1'b0};
                o_sda_oe <= !tx_sh[TWF_WORD_BITS-2];
              end
            end
          end
          TWF_ACK_TX: begin
            if (scl_rise) begin
              host_ack <= !sda_q;
            end
            if (scl_fall) begin
              if (host_ack && i_tx_valid) begin
                tx_sh <= i_tx_data;
                o_sda_oe <= !i_tx_data[TWF_WORD_BITS-1];
                o_tx_take <= 1'b1;
                state <= TWF_TX;
              end else begin
                o_sda_oe <= 1'b0;
                state <= TWF_WAIT_STOP;
              end
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
            state <= TWF_IDLE;
          end
        endcase
      end
    end
  end

  // Standby after a read ends, left at the next start
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_standby <= 1'b1;
    end else if (start_det) begin
      o_standby <= 1'b0;
    end else if (stop_det && read_seq) begin
      o_standby <= 1'b1;
    end
  end

  // Self-timed internal write, exactly P_WRITE_CYCLES long
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_write_busy <= 1'b0;
      wr_cnt <= TWF_WCNT_ZERO;
    end else if (o_write_busy) begin
      if (wr_cnt == TWF_WCNT_ZERO) begin
        o_write_busy <= 1'b0;
      end else begin
        wr_cnt <= wr_cnt - TWF_WCNT_ONE;
      end
    end else if (stop_det && wrote && !read_seq) begin
      o_write_busy <= 1'b1;
      wr_cnt <= WCNT_LOAD;
    end
  end

  // Output stage so receive outputs come from flip-flops
  assign rd_if.ready = !o_rx_valid || i_rx_ready;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= TWF_BYTE_ZERO;
    end else if (rd_if.ready) begin
      o_rx_valid <= rd_if.valid;
      if (rd_if.valid) begin
        o_rx_data <= rd_if.data;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_word_in;
    word_fall && wr_if.ready;
  endsequence
  sequence s_ack_held;
    (state == TWF_ACK_RX) && !scl_fall && !start_det && !stop_det;
  endsequence

  property p_oe_low_clock;
    $changed(o_sda_oe) |-> !$past(scl_q);
  endproperty
  a_oe_low_clock: assert property (p_oe_low_clock)
    else $error("data line enable changed while clock high");
  property p_start;
    start_det && !o_write_busy |=> (state == TWF_RX) && (bit_cnt == TWF_BIT_ZERO) && !o_sda_oe;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not begin a new command");
  property p_stop;
    stop_det |=> (state == TWF_IDLE) && !o_sda_oe;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not end the sequence");
  property p_standby;
    stop_det && read_seq |=> o_standby ##1 (o_standby || $past(start_det));
  endproperty
  a_standby: assert property (p_standby)
    else $error("no standby after read stop");
  property p_bit_shift;
    scl_rise && (state == TWF_RX) && (bit_cnt != TWF_BIT_FULL) && !start_det && !stop_det
      |=> (rx_sh[0] == $past(sda_q)) && (bit_cnt == $past(bit_cnt) + TWF_BIT_ONE);
  endproperty
  a_bit_shift: assert property (p_bit_shift)
    else $error("received bit not shifted in");
  property p_ack;
    s_word_in |=> o_sda_oe && (state == TWF_ACK_RX);
  endproperty
  a_ack: assert property (p_ack)
    else $error("received word not acknowledged");
  property p_ack_hold;
    s_ack_held |=> o_sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge released early");
  property p_write_busy;
    stop_det && wrote && !read_seq && !o_write_busy
      |=> o_write_busy && (wr_cnt == WCNT_LOAD);
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("internal write not started after write stop");
  property p_write_bound;
    o_write_busy && (wr_cnt != TWF_WCNT_ZERO)
      |=> o_write_busy && (wr_cnt == $past(wr_cnt) - TWF_WCNT_ONE);
  endproperty
  a_write_bound: assert property (p_write_bound)
    else $error("internal write count did not step down");
  property p_tx_change;
    (state == TWF_TX) && $changed(o_sda_oe) |-> $past(scl_fall);
  endproperty
  a_tx_change: assert property (p_tx_change)
    else $error("outgoing bit changed away from clock fall");
  property p_never_high;
    (o_sda_o == 1'b0) && (!o_sda_oe || (state == TWF_ACK_RX) || (state == TWF_TX));
  endproperty
  a_never_high: assert property (p_never_high)
    else $error("data line driven high or pulled outside a transfer");
  property p_restart;
    (start_det || stop_det) && (state == TWF_RX) |=> (bit_cnt == TWF_BIT_ZERO);
  endproperty
  a_restart: assert property (p_restart)
    else $error("partial word kept after start or stop");
endmodule

// ===== sim/twf_host.sv
`timescale 1ns/1ps
module twf_host (
  output logic o_scl,
  output logic o_pull,
  input wire logic i_sda
);
  // Quarter of a 125 ns serial clock period
  localparam real Q = 31.25;
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  // Data set only while clock low; line only pulled low or released
  task automatic bit_io(input logic b, output logic r);
    o_pull = ~b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    o_pull = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_pull = 1'b1;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    o_pull = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_pull = 1'b0;
    #Q;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Host acknowledges unless last; the recovery poll is built from wr_byte, not these
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ===== sim/twf_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin compares++; if ((got) !== (exp)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); n_mismatch++; end end
module twf_top_bench;
  import twf_pkg::*;
  localparam int P_WR = 2000;
  localparam int LIMIT = 30000;
  logic clk = 1'b0;
  logic rst_b;
  logic scl;
  logic pull;
  wire sda;
  logic oe;
  logic oe_q = 1'b0;
  logic sda_o;
  logic dir_read;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_take;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ready;
  logic standby;
  logic busy;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int busy_run = 0;
  int busy_len = 0;
  int takes = 0;
  logic [7:0] rxq[$];
  logic [7:0] tx_tab [0:1] = '{8'h96, 8'h5a};
  logic [7:0] wr_tab [0:2] = '{8'ha5, 8'h3c, 8'h81};

  always #2 clk = ~clk;
  assign sda = (oe ? sda_o : 1'b1) & ~pull;

  twf_top #(.P_WRITE_CYCLES(P_WR)) twf_top_inst (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o),
    .o_sda_oe(oe), .i_dir_read(dir_read), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_take(tx_take), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_rx_ready(rx_ready), .o_standby(standby), .o_write_busy(busy)
  );
  twf_host twf_host_inst (.o_scl(scl), .o_pull(pull), .i_sda(sda));

  task test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    if (busy === 1'b1) busy_run++;
    else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
    if (oe === 1'b1) `CHK("drive_value", 1'b0, sda_o)
    if (oe !== oe_q) `CHK("oe_change_scl", 1'b0, scl)
    oe_q = oe;
    if (cyc == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end

  always @(negedge clk) begin
    if (tx_take === 1'b1) begin
      takes++;
      tx_data <= tx_tab[1];
    end
  end

  task automatic wait_busy(input logic v);
    int i;
    i = 0;
    while (busy !== v && i < 3000) begin
      @(negedge clk);
      i++;
    end
  endtask

  task automatic t_write;
    logic ack;
    int polls;
    rxq.delete();
    twf_host_inst.start();
    `CHK("standby_after_start", 1'b0, standby)
    for (int i = 0; i < 3; i++) begin
      twf_host_inst.wr_byte(wr_tab[i], ack);
      `CHK("write_ack", 1'b1, ack)
    end
    twf_host_inst.stop();
    wait_busy(1'b1);
    `CHK("busy_after_stop", 1'b1, busy)
    `CHK("no_standby_after_write", 1'b0, standby)
    polls = 0;
    ack = 1'b0;
    while (!ack && polls < 20) begin
      twf_host_inst.start();
      twf_host_inst.wr_byte(8'hb6, ack);
      twf_host_inst.stop();
      polls++;
    end
    `CHK("poll_refused_first", 1'b1, polls > 1)
    `CHK("poll_ack", 1'b1, ack)
    `CHK("busy_cycles", P_WR, busy_len)
    `CHK("rx_count", 4, rxq.size())
    for (int i = 0; i < 3; i++) begin
      `CHK("rx_word", wr_tab[i], rxq[i])
    end
  endtask

  task automatic t_read;
    logic ack;
    logic [7:0] d;
    @(negedge clk);
    takes = 0;
    dir_read = 1'b1;
    tx_valid = 1'b1;
    tx_data = tx_tab[0];
    twf_host_inst.start();
    twf_host_inst.wr_byte(8'hb7, ack);
    `CHK("read_cmd_ack", 1'b1, ack)
    twf_host_inst.rd_byte(1'b0, d);
    `CHK("read_byte0", tx_tab[0], d)
    twf_host_inst.rd_byte(1'b1, d);
    `CHK("read_byte1", tx_tab[1], d)
    twf_host_inst.stop();
    repeat (8) @(negedge clk);
    `CHK("standby_after_read", 1'b1, standby)
    `CHK("tx_takes", 2, takes)
    `CHK("no_busy_after_read", 1'b0, busy)
    tx_valid = 1'b0;
    twf_host_inst.start();
    twf_host_inst.wr_byte(8'hb7, ack);
    twf_host_inst.rd_byte(1'b1, d);
    twf_host_inst.stop();
    `CHK("read_empty_ack", 1'b1, ack)
    `CHK("read_empty_byte", 8'hff, d)
    `CHK("read_empty_takes", 2, takes)
    dir_read = 1'b0;
  endtask

  task automatic t_abort;
    logic ack;
    logic r;
    rxq.delete();
    twf_host_inst.start();
    for (int i = 0; i < 4; i++) twf_host_inst.bit_io(1'b1, r);
    twf_host_inst.start();
    twf_host_inst.wr_byte(8'hc3, ack);
    twf_host_inst.stop();
    `CHK("abort_ack", 1'b1, ack)
    `CHK("abort_rx_count", 1, rxq.size())
    `CHK("abort_rx_word", 8'hc3, rxq[0])
  endtask

  task automatic t_full;
    logic ack;
    @(negedge clk);
    rx_ready = 1'b0;
    rxq.delete();
    twf_host_inst.start();
    for (int i = 0; i < 10; i++) begin
      twf_host_inst.wr_byte(8'h10 + i[7:0], ack);
      `CHK("full_ack", i < 9, ack)
    end
    twf_host_inst.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    rx_ready = 1'b1;
    repeat (40) @(negedge clk);
    `CHK("drain_count", 9, rxq.size())
    for (int i = 0; i < 9; i++) begin
      `CHK("drain_word", 8'h10 + i[7:0], rxq[i])
    end
  endtask

  task automatic t_reset;
    logic ack;
    twf_host_inst.start();
    twf_host_inst.wr_byte(8'h21, ack);
    twf_host_inst.wr_byte(8'h22, ack);
    twf_host_inst.stop();
    wait_busy(1'b1);
    `CHK("busy_before_reset", 1'b1, busy)
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("mid_reset_busy", 1'b0, busy)
    `CHK("mid_reset_standby", 1'b1, standby)
    `CHK("mid_reset_oe", 1'b0, oe)
    `CHK("mid_reset_rx_valid", 1'b0, rx_valid)
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    twf_host_inst.start();
    twf_host_inst.wr_byte(8'h42, ack);
    twf_host_inst.stop();
    `CHK("post_reset_ack", 1'b1, ack)
    `CHK("post_reset_busy", 1'b0, busy)
  endtask

  initial begin
    rst_b = 1'b0;
    dir_read = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("reset_standby", 1'b1, standby)
    `CHK("reset_busy", 1'b0, busy)
    `CHK("reset_oe", 1'b0, oe)
    `CHK("reset_rx_valid", 1'b0, rx_valid)
    t_write();
    t_read();
    t_abort();
    t_full();
    t_reset();
    test_done();
  end
endmodule
